// ===== hw/led_afe_regs.sv
// register bank for channel-three current, front end, dead time and interrupt flags
`timescale 1ns/100ps
module led_afe_regs
  import led_afe_pkg::*;
#(
  parameter int LOCKOUT_CYCLES = LOCKOUT_DELAY_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  input  wire logic       front_end_on,
  input  wire logic       comparator_in,
  output logic            comparator_out,
  output logic            comparator_oe,
  input  wire logic [1:0] led_channel_select_in,
  input  wire logic [7:0] event_in,
  output logic      [2:0] led_switch_on,
  output logic      [9:0] ch6_current_code,
  output logic            factory_trim_bypass,
  output logic      [1:0] amplifier_gain_select,
  output logic      [2:0] front_end_input_select,
  output logic            interrupt_out_n,
  output logic            mirror_regulator_enable,
  output logic            serial_enable
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0]  ch6_current_low_byte;
  logic [1:0]  ch6_current_high;
  logic [7:0]  switch_dead_time;
  logic [7:0]  interrupt_status;
  logic [7:0]  interrupt_mask;
  logic        front_end_enabled_flag;
  logic        lockout_pending;
  logic [31:0] lockout_count;
  logic [7:0]  next_rd_data;
  strobe_if    sif ();

  assign sif.dead_code   = switch_dead_time;
  assign sif.channel_sel = led_channel_select_in;

  strobe_sequencer u_seq (
    .clk (clk),
    .rst (rst),
    .sif (sif)
  );

  // ****************************************
  // host writes
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ch6_current_low_byte   <= RESET_BYTE;
      ch6_current_high       <= 2'b00;
      switch_dead_time       <= RESET_BYTE;
      interrupt_mask         <= RESET_BYTE;
      factory_trim_bypass    <= 1'b0;
      amplifier_gain_select  <= GAIN_OFF;
      front_end_input_select <= SEL_SENSOR_TWO;
    end else if (wr_en && serial_enable) begin
      unique case (addr)
        ADDR_CH6_CURRENT_LOW:  ch6_current_low_byte <= wr_data; // RL1
        ADDR_CH6_CURRENT_HIGH: ch6_current_high <= wr_data[CODE_HIGH_BITS-1:0]; // RL11 RL14
        ADDR_FRONT_END_CTRL: begin
          factory_trim_bypass    <= wr_data[FE_TRIM_BIT]; // RL4
          amplifier_gain_select  <= wr_data[FE_GAIN_MSB:FE_GAIN_LSB]; // RL5
          front_end_input_select <= wr_data[FE_SEL_MSB:FE_SEL_LSB]; // RL6 RL14
        end
        ADDR_DEAD_TIME:        switch_dead_time <= wr_data; // RL7
        ADDR_INT_MASK:         interrupt_mask   <= wr_data;
        default: ;
      endcase
    end
  end

  // ****************************************
  // status, front end and code outputs
  // ****************************************
  // no reset on flags: their value after reset is undefined
  always_ff @(posedge clk) begin
    interrupt_status <= event_in; // RL9 RL10
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      front_end_enabled_flag <= 1'b0;
      comparator_out         <= 1'b0;
      comparator_oe          <= 1'b0;
      ch6_current_code       <= 10'h000;
      led_switch_on          <= 3'b000;
      interrupt_out_n        <= 1'b1;
    end else begin
      front_end_enabled_flag <= front_end_on;
      comparator_out         <= comparator_in;
      comparator_oe          <= front_end_on; // RL3
      ch6_current_code       <= {ch6_current_high, ch6_current_low_byte}; // RL2 RL11
      led_switch_on          <= sif.switch_on;
      interrupt_out_n        <= ~|(interrupt_status & ~interrupt_mask); // RL12
    end
  end

  // ****************************************
  // undervoltage lockout
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      mirror_regulator_enable <= 1'b1;
      lockout_pending         <= 1'b0;
      lockout_count           <= 32'h0000_0000;
      serial_enable           <= 1'b1;
    end else if (event_in[FLAG_UNDERVOLTAGE_LOCKOUT_FLAG_BIT] && !lockout_pending && serial_enable) begin
      mirror_regulator_enable <= 1'b0; // RL13
      lockout_pending         <= 1'b1;
      lockout_count           <= 32'(LOCKOUT_CYCLES - 1);
    end else if (lockout_pending) begin
      if (lockout_count == 32'h0000_0000) begin
        serial_enable   <= 1'b0; // RL13
        lockout_pending <= 1'b0;
      end else begin
        lockout_count <= lockout_count - 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // host reads
  // ****************************************
  always_comb begin
    next_rd_data = RESERVED_READ;
    unique case (addr)
      ADDR_CH6_CURRENT_LOW:  next_rd_data = ch6_current_low_byte;
      ADDR_CH6_CURRENT_HIGH: next_rd_data = {6'h00, ch6_current_high};
      ADDR_FRONT_END_CTRL:   next_rd_data = {1'b0, front_end_enabled_flag, factory_trim_bypass,
                                             amplifier_gain_select, front_end_input_select}; // RL3 RL14
      ADDR_DEAD_TIME:        next_rd_data = switch_dead_time;
      ADDR_INT_STATUS:       next_rd_data = interrupt_status; // RL9
      ADDR_INT_MASK:         next_rd_data = interrupt_mask;
      default:               next_rd_data = RESERVED_READ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= RESERVED_READ;
    end else if (rd_en && serial_enable) begin
      rd_data <= next_rd_data;
    end
  end
endmodule

// ===== shared/led_afe_pkg.sv
// constants and types for the led front-end, strobe and interrupt register slice
// Function
// [RL1] the low eight bits of the third channel current code are a read-write byte at bits 7 to 0.
// [RL2] a current code of zero commands no current and each code step adds one typical current step.
// [RL3] the front-end enable flag at bit 6 is read-only and while low the comparator output is not driven.
// [RL4] calibration-disable bit 5 low uses the factory trim and high bypasses it.
// [RL5] the gain field at bits 4 to 3 selects off, unity, 9.5 times or 18 times.
// [RL6] the mux field at bits 2 to 0 routes sensor two, led supply, battery, sensor one, limit node or switches a to c.
// [RL7] the dead-time code sets 222 ns plus 111 ns per step between opening one switch set and closing the next.
// [RL8] after a change on the channel select input the closed switches open within 333 to 444 ns, then the dead time runs.
// [RL9] the interrupt status register holds eight read-only event flags in the documented order.
// [RL10] the interrupt status flags have no defined value after reset.
// [RL11] the two high current-code bits live in bits 1 to 0 of a separate register.
// [RL12] a set mask bit keeps its flag from pulling the interrupt output low while the flag still reads set.
// [RL13] an undervoltage event clears the mirror regulator enable and about 25 ms later disables the serial interface.
// [RL14] writes to read-only or reserved bits are ignored and those bits keep their device values.
// [RL15] the host must program a dead time long enough for the previous switch set to be fully off.
package led_afe_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CH6_CURRENT_HIGH = 8'h07;
  localparam logic [7:0] ADDR_CH6_CURRENT_LOW  = 8'h08;
  localparam logic [7:0] ADDR_FRONT_END_CTRL   = 8'h0a;
  localparam logic [7:0] ADDR_DEAD_TIME        = 8'h0b;
  localparam logic [7:0] ADDR_INT_STATUS       = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK         = 8'h0d;
  localparam logic [7:0] RESET_BYTE            = 8'h00;
  localparam logic [7:0] RESERVED_READ         = 8'h00;
  localparam int CODE_HIGH_BITS   = 2;
  localparam int FE_ENABLE_BIT    = 6;
  localparam int FE_TRIM_BIT      = 5;
  localparam int FE_GAIN_MSB      = 4;
  localparam int FE_GAIN_LSB      = 3;
  localparam int FE_SEL_MSB       = 2;
  localparam int FE_SEL_LSB       = 0;
  localparam int FLAG_UNDERVOLTAGE_LOCKOUT_FLAG_BIT    = 3;
  // ****************************************
  // field encodings
  // ****************************************
  typedef enum logic [1:0] {
    GAIN_OFF   = 2'b00,
    GAIN_UNITY = 2'b01,
    GAIN_X9P5  = 2'b10,
    GAIN_X18   = 2'b11
  } amp_gain_e;
  typedef enum logic [2:0] {
    SEL_SENSOR_TWO   = 3'b000,
    SEL_LED_SUPPLY   = 3'b001,
    SEL_BATTERY      = 3'b010,
    SEL_SENSOR_ONE   = 3'b011,
    SEL_CURRENT_LIM  = 3'b100,
    SEL_LED_SWITCH_A = 3'b101,
    SEL_LED_SWITCH_B = 3'b110,
    SEL_LED_SWITCH_C = 3'b111
  } fe_input_e;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 20;
  localparam int DEAD_BASE_NS      = 222;
  localparam int DEAD_STEP_NS      = 111;
  localparam int OFF_LATENCY_MIN_NS = 333;
  localparam int OFF_LATENCY_MAX_NS = 444;
  localparam int LOCKOUT_DELAY_MS  = 25;
  localparam int DEAD_BASE_CYC  = (DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_STEP_CYC  = (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_LATENCY_CYC = (OFF_LATENCY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCKOUT_DELAY_CYC = LOCKOUT_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SW_CLOSED = 2'b00,
    SW_OPENING = 2'b01,
    SW_DEAD    = 2'b10
  } switch_state_e;
endpackage

// ===== shared/strobe_if.sv
// carrier between register bank and strobe sequencer
`timescale 1ns/100ps
interface strobe_if;
  logic [7:0] dead_code;
  logic [1:0] channel_sel;
  logic [2:0] switch_on;
  modport bank (output dead_code, output channel_sel, input switch_on);
  modport seq  (input dead_code, input channel_sel, output switch_on);
endinterface

// ===== hw/strobe_sequencer.sv
// break-before-make sequencer for the three led switches
`timescale 1ns/100ps
module strobe_sequencer
  import led_afe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  strobe_if.seq    sif
);
  switch_state_e state;
  logic [1:0]    last_sel;
  logic [15:0]   count;

  function automatic logic [15:0] dead_cycles(input logic [7:0] code);
    // rounded up once on the whole span, so per-step rounding cannot pile up at high codes
    dead_cycles = 16'((DEAD_BASE_NS + int'(code) * DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  function automatic logic [2:0] decode_sel(input logic [1:0] sel);
    decode_sel = (sel == 2'b00) ? 3'b000 : 3'((3'b001) << (sel - 2'b01));
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= SW_CLOSED;
      last_sel <= 2'b00;
      count    <= 16'h0000;
      sif.switch_on <= 3'b000;
    end else begin
      unique case (state)
        SW_CLOSED: begin
          if (sif.channel_sel != last_sel) begin
            last_sel <= sif.channel_sel;
            count    <= 16'(OFF_LATENCY_CYC - 1);
            state    <= SW_OPENING;
          end
        end
        SW_OPENING: begin
          if (count == 16'h0000) begin
            sif.switch_on <= 3'b000; // RL8
            count         <= dead_cycles(sif.dead_code); // RL7
            state         <= SW_DEAD;
          end else begin
            count <= count - 16'h0001;
          end
        end
        SW_DEAD: begin
          if (count <= 16'h0001) begin
            sif.switch_on <= decode_sel(last_sel); // RL7
            state         <= SW_CLOSED;
          end else begin
            count <= count - 16'h0001;
          end
        end
        default: state <= SW_CLOSED;
      endcase
    end
  end
endmodule

// ===== bench/led_afe_regs_monitor.sv
// assertion checker for the led front-end register bank
`timescale 1ns/100ps
module led_afe_regs_monitor
  import led_afe_pkg::*;
#(
  parameter int LOCKOUT_CYCLES = LOCKOUT_DELAY_CYC
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] rd_data,
  input wire logic       front_end_on,
  input wire logic       comparator_oe,
  input wire logic [1:0] led_channel_select_in,
  input wire logic [7:0] event_in,
  input wire logic [2:0] led_switch_on,
  input wire logic       interrupt_out_n,
  input wire logic       mirror_regulator_enable,
  input wire logic       serial_enable
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sel_change;
    $changed(led_channel_select_in);
  endsequence
  sequence s_all_open;
    led_switch_on == 3'h0;
  endsequence
  a_reset_values: assert property ($past(rst) |-> rd_data == 8'h00 && led_switch_on == 3'h0 && interrupt_out_n
    && mirror_regulator_enable && serial_enable) else $error("bad value after reset");
  a_uv_regulator: assert property (event_in[FLAG_UNDERVOLTAGE_LOCKOUT_FLAG_BIT] |=> !mirror_regulator_enable)
    else $error("regulator still enabled");
  a_lock_sticky: assert property (!serial_enable |=> !serial_enable) else $error("serial port came back");
  a_lock_delay: assert property ($rose(event_in[FLAG_UNDERVOLTAGE_LOCKOUT_FLAG_BIT]) && serial_enable |-> serial_enable[*8])
    else $error("serial port closed early");
  a_switch_open: assert property (s_sel_change |-> ##[17:22] s_all_open) else $error("switches opened late");
  a_dead_gap: assert property (led_switch_on != 3'h0 && $past(led_switch_on) == 3'h0
    |-> $past(led_switch_on, 12) == 3'h0) else $error("dead time too short");
  a_comp_hiz: assert property (!$past(front_end_on) && !$past(front_end_on, 2) |-> !comparator_oe)
    else $error("comparator driven while off");
  a_int_quiet: assert property ($past(event_in) == 8'h00 && $past(event_in, 2) == 8'h00 |-> interrupt_out_n)
    else $error("interrupt without event");
endmodule
bind led_afe_regs led_afe_regs_monitor #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) mon (.clk, .rst, .rd_data, .front_end_on,
  .comparator_oe, .led_channel_select_in, .event_in, .led_switch_on, .interrupt_out_n, .mirror_regulator_enable,
  .serial_enable);

// ===== bench/reg_host.sv
// register host model issuing single-cycle reads and writes
`timescale 1ns/100ps
module reg_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] addr,
  output logic      [7:0] wr_data
);
  logic [7:0] last_rd;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // released address and data are inverted so stale values never pass
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    wr_en = wr;
    rd_en = !wr;
    addr = a;
    wr_data = v;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = ~a;
    wr_data = ~v;
    @(negedge clk);
    last_rd = rd_data;
  endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the led front-end register bank
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t mismatch", $time); end end
module testbench
  import led_afe_pkg::*;
;
  logic       clk, rst, front_end_on, comparator_in, wr_en, rd_en, comparator_out, comparator_oe;
  logic       factory_trim_bypass, interrupt_out_n, mirror_regulator_enable, serial_enable;
  logic [7:0] addr, wr_data, rd_data, event_in, d, m[logic [7:0]];
  logic [7:0] regs[7] = '{ADDR_CH6_CURRENT_HIGH, ADDR_CH6_CURRENT_LOW, ADDR_FRONT_END_CTRL, ADDR_DEAD_TIME,
                          ADDR_INT_MASK, 8'h3f, ADDR_INT_STATUS};
  logic [7:0] dcode[3] = '{8'h00, 8'h03, 8'hff};
  logic [1:0] led_channel_select_in, amplifier_gain_select;
  logic [2:0] led_switch_on, front_end_input_select;
  logic [9:0] ch6_current_code;
  int         err_total, total_checks, seed, n, c, g;
  led_afe_regs #(.LOCKOUT_CYCLES(20)) dut (.clk, .rst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .front_end_on,
    .comparator_in, .comparator_out, .comparator_oe, .led_channel_select_in, .event_in, .led_switch_on,
    .ch6_current_code, .factory_trim_bypass, .amplifier_gain_select, .front_end_input_select, .interrupt_out_n,
    .mirror_regulator_enable, .serial_enable);
  reg_host host (.clk, .rd_data, .wr_en, .rd_en, .addr, .wr_data);
  // ****************************************
  // model and tasks
  // ****************************************
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == ADDR_FRONT_END_CTRL) return {1'b0, front_end_on, m[a][5:0]};
    if (a == ADDR_INT_STATUS) return event_in;
    return m.exists(a) ? m[a] : 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.access(1'b1, a, v);
    if (a == ADDR_CH6_CURRENT_HIGH) m[a] = v & 8'h03;
    else if (a == ADDR_FRONT_END_CTRL) m[a] = v & 8'h3f;
    else if (m.exists(a)) m[a] = v;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    host.access(1'b0, a, 8'h00);
    `CHK(host.last_rd, exp_rd(a))
  endtask
  task automatic out_chk();
    `CHK(ch6_current_code, {m[ADDR_CH6_CURRENT_HIGH][1:0], m[ADDR_CH6_CURRENT_LOW]})
    `CHK({factory_trim_bypass, amplifier_gain_select, front_end_input_select}, m[ADDR_FRONT_END_CTRL][5:0])
    `CHK(interrupt_out_n, ~|(event_in & ~m[ADDR_INT_MASK]))
    `CHK(comparator_oe, front_end_on)
    if (front_end_on) `CHK(comparator_out, comparator_in)
  endtask
  task automatic count_until(input logic want_on, output int cnt);
    cnt = 0;
    while (((led_switch_on !== 3'h0) != want_on) && cnt < 2000) begin
      @(negedge clk);
      cnt++;
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(20 * 5000);
    err_total++;
    end_of_test();
  end
  initial begin
    seed = 25;
    rst = 1'b1;
    front_end_on = 1'b0;
    comparator_in = 1'b0;
    event_in = 8'h00;
    led_channel_select_in = 2'd0;
    for (n = 0; n < 5; n++) m[regs[n]] = 8'h00;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    // status is left out until events are driven
    for (n = 0; n < 6; n++) rd_chk(regs[n]);
    for (n = 0; n < 28; n++) begin
      d = 8'($random(seed));
      front_end_on = d[6];
      comparator_in = d[1];
      event_in = 8'($random(seed)) & 8'hf7;
      wr(regs[n % 7], d);
      rd_chk(regs[n % 7]);
      out_chk();
    end
    for (n = 0; n < 8; n++) begin
      wr(ADDR_FRONT_END_CTRL, {2'b11, n[0], n[1:0], n[2:0]});
      rd_chk(ADDR_FRONT_END_CTRL);
      out_chk();
    end
    for (n = 0; n < 3; n++) begin
      wr(ADDR_DEAD_TIME, dcode[n]);
      led_channel_select_in = 2'(n + 1);
      count_until(1'b0, c);
      count_until(1'b1, g);
      if (n > 0) begin
        `CHK(c * CLK_PERIOD_NS inside {[OFF_LATENCY_MIN_NS - 20 : OFF_LATENCY_MAX_NS + 20]}, 1'b1)
        `CHK(g * CLK_PERIOD_NS < DEAD_BASE_NS + DEAD_STEP_NS * dcode[n] + CLK_PERIOD_NS, 1'b1)
      end
      `CHK(g * CLK_PERIOD_NS >= DEAD_BASE_NS + DEAD_STEP_NS * dcode[n], 1'b1)
      `CHK(led_switch_on, 3'b001 << n)
    end
    wr(ADDR_DEAD_TIME, 8'h00);
    led_channel_select_in = 2'd0;
    count_until(1'b0, c);
    `CHK(c * CLK_PERIOD_NS inside {[OFF_LATENCY_MIN_NS - 20 : OFF_LATENCY_MAX_NS + 20]}, 1'b1)
    repeat (40) @(negedge clk);
    `CHK(led_switch_on, 3'b000)
    event_in = 8'h08;
    repeat (2) @(negedge clk);
    `CHK({mirror_regulator_enable, serial_enable}, 2'b01)
    repeat (30) @(negedge clk);
    `CHK(serial_enable, 1'b0)
    host.access(1'b1, ADDR_CH6_CURRENT_LOW, ~m[ADDR_CH6_CURRENT_LOW]);
    out_chk();
    end_of_test();
  end
endmodule
